/* sabd_pkg.sv */
package sabd_pkg;
  // ==========================================================
  // Rate prescale counts (base clock divide, per oscillator)
  localparam int unsigned DIV_BOTH_LOW  = 64;
  localparam int unsigned DIV_ONE_HIGH  = 16;
  localparam int unsigned DIV_BOTH_HIGH = 4;
  localparam int unsigned ABD_FACTOR    = 8;
  // ==========================================================
  // Calibration character and edge count
  localparam logic [7:0] SYNC_CHAR     = 8'h55;
  localparam logic [2:0] RISE_EDGES    = 3'h5;
  localparam logic [15:0] CNT_PRELOAD  = 16'h0001;
  // ==========================================================
  // Divisor reset value
  localparam logic [15:0] DIV_RESET    = 16'h0000;
  // ==========================================================
  // Link idle level
  localparam logic        LINE_IDLE    = 1'b1;
  // ==========================================================
  // Remote node: break low time in bit periods
  localparam int unsigned BREAK_BITS   = 13;
endpackage

/* sabd_if.sv */
`timescale 1ns/1ns
interface sabd_if;
  logic rx_line;
  modport device (input rx_line);
  modport remote (output rx_line);
endinterface

/* sabd_remote.sv */
`timescale 1ns/1ns
module sabd_remote
  import sabd_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = 10416
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // User side
  input  wire logic send_sync,
  input  wire logic send_break,
  output logic      busy,
  // Link
  sabd_if.remote    link
);
  // ==========================================================
  // Frame shifter: start, 8 data lsb first, stop
  logic [31:0] bit_cnt_q;
  logic [4:0]  idx_q;
  logic [4:0]  last_q;
  logic        brk_q;
  logic        tx_q;
  logic        busy_q;
  wire         bit_end  = (bit_cnt_q == BIT_CYCLES - 1);
  wire         start    = !busy_q && (send_sync || send_break);
  wire [4:0]   nxt      = idx_q + 5'd1;
  wire         data_bit = (idx_q >= 5'd1 && idx_q <= 5'd8) ?
                          SYNC_CHAR[3'(idx_q - 5'd1)] : 1'b1;
  wire         line_d   = brk_q ? (idx_q < 5'(BREAK_BITS)) ? 1'b0 : 1'b1
                        : (idx_q == 5'd0) ? 1'b0 : data_bit;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 32'h0;
      idx_q     <= 5'h0;
      last_q    <= 5'h0;
      brk_q     <= 1'b0;
      busy_q    <= 1'b0;
      tx_q      <= LINE_IDLE;
    end else if (start) begin
      busy_q    <= 1'b1;
      brk_q     <= send_break;
      last_q    <= send_break ? 5'(BREAK_BITS) : 5'd9;
      idx_q     <= 5'h0;
      bit_cnt_q <= 32'h0;
      tx_q      <= 1'b0;
    end else if (busy_q) begin
      if (bit_end) begin
        bit_cnt_q <= 32'h0;
        if (idx_q == last_q) begin
          busy_q <= 1'b0;
          tx_q   <= LINE_IDLE;
        end else begin
          idx_q <= nxt;
        end
      end else begin
        bit_cnt_q <= bit_cnt_q + 32'h1;
        tx_q      <= line_d;
      end
    end
  end
  assign link.rx_line = tx_q;
  assign busy         = busy_q;
endmodule

/* sabd_device.sv */
// Behaviour
// - Setting enable starts baud measurement
// - Serial state machine idle while measuring
// - Receive line gates the divisor counter
// - Remote sends 55h, five rising edges
// - Count starts first rise after start
// - Fifth rising edge ends measurement
// - Keep count, clear enable, set flag
// - Data register read clears receive flag
// - Software checks high byte zero
// - Base clock 64/16/4 divide, counter eighth
// - Both divisor bytes count as sixteen bits
// - Counter at one eighth base rate
// - Wake enable: measure byte after break
// - Counter preloads one; software subtracts one
// - Wide select uses full 16-bit divisor in sync mode or with high speed
`timescale 1ns/1ns
module sabd_device
  import sabd_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Control
  input  wire logic        auto_baud_enable_set,
  input  wire logic        wake_on_break_enable,
  input  wire logic        wide_divisor_select,
  input  wire logic        high_speed_select,
  input  wire logic        sync_mode,
  input  wire logic        receive_data_read,
  input  wire logic        div_write,
  input  wire logic [15:0] div_wdata,
  // Status
  output logic             auto_baud_enable,
  output logic             receive_interrupt_flag,
  output logic [7:0]       divisor_low_byte,
  output logic [7:0]       divisor_high_byte,
  output logic             serial_idle,
  output logic             bit_tick,
  // Link
  sabd_if.device           link
);
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_BREAK = 3'b001,
    ST_WSTRT = 3'b010,
    ST_WRISE = 3'b011,
    ST_COUNT = 3'b100
  } sabd_state_t;
  // ==========================================================
  // Registers
  sabd_state_t state_q, state_d;
  logic [15:0] div_q;
  logic [9:0]  pre_q;
  logic [17:0] bit_q;
  logic [2:0]  edges_q;
  logic        rx_q;
  logic        en_q;
  logic        flag_q;
  logic        tick_q;
  logic        idle_q;
  // ==========================================================
  // Prescale selection
  wire [1:0] rate_sel = {wide_divisor_select, high_speed_select};
  wire [8:0] base_div = (rate_sel == 2'b00) ? 9'(DIV_BOTH_LOW) :
                        (rate_sel == 2'b11) ? 9'(DIV_BOTH_HIGH) :
                        9'(DIV_ONE_HIGH);
  wire [9:0] abd_div  = 10'(base_div * ABD_FACTOR);
  wire       pre_end  = (pre_q == abd_div - 10'd1);
  wire       rise     = link.rx_line && !rx_q;
  wire       fall     = !link.rx_line && rx_q;
  wire       measure  = (state_q != ST_OFF);
  wire       meas_nxt = (state_d != ST_OFF);
  wire       in_count = (state_q == ST_COUNT);
  wire       done     = in_count && rise &&
                        (edges_q == RISE_EDGES - 3'd1);
  wire       rise_one = (state_q == ST_WRISE) && rise;
  wire       rise_cnt = in_count && rise;
  wire       pre_run  = in_count && !pre_end;
  wire       div_step = in_count && !done && pre_end;
  wire       div_load = div_write && !measure;
  wire       wide     = (!sync_mode && high_speed_select &&
                         wide_divisor_select) ||
                        (sync_mode && wide_divisor_select);
  wire [15:0] period_m1 = wide ? div_q : {8'h00, div_q[7:0]};
  wire [17:0] bit_last  = {period_m1, 2'b11};
  wire       bit_end  = (bit_q >= bit_last);
  wire       hold_bit = measure || bit_end;
  wire       tick_d   = bit_end && !measure && !meas_nxt;
  // ==========================================================
  // Measurement sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF:
        if (auto_baud_enable_set)
          state_d = wake_on_break_enable ? ST_BREAK : ST_WSTRT;
      ST_BREAK:
        if (rise) state_d = ST_WSTRT;
      ST_WSTRT:
        if (fall) state_d = ST_WRISE;
      ST_WRISE:
        if (rise) state_d = ST_COUNT;
      ST_COUNT:
        if (done) state_d = ST_OFF;
      default:
        state_d = ST_OFF;
    endcase
  end
  // ==========================================================
  // State and line sampler
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_OFF;
      rx_q    <= LINE_IDLE;
    end else begin
      state_q <= state_d;
      rx_q    <= link.rx_line;
    end
  end
  // ==========================================================
  // Rising edges seen within the sync character
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      edges_q <= 3'h0;
    end else if (rise_one) begin
      edges_q <= 3'h1;
    end else if (rise_cnt) begin
      edges_q <= edges_q + 3'h1;
    end
  end
  // ==========================================================
  // Counter clock prescaler, eighth of base clock
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 10'h0;
    end else if (pre_run) begin
      pre_q <= pre_q + 10'h1;
    end else begin
      pre_q <= 10'h0;
    end
  end
  // ==========================================================
  // Divisor pair, counting as one 16-bit counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_q <= DIV_RESET;
    end else if (rise_one) begin
      div_q <= CNT_PRELOAD;
    end else if (div_step) begin
      div_q <= div_q + 16'h1;
    end else if (div_load) begin
      div_q <= div_wdata;
    end
  end
  // ==========================================================
  // Enable bit, cleared by itself at the end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= meas_nxt;
    end
  end
  // ==========================================================
  // Receive flag, set wins over a read
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (done) begin
      flag_q <= 1'b1;
    end else if (receive_data_read) begin
      flag_q <= 1'b0;
    end
  end
  // ==========================================================
  // Bit period generator, held while measuring
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bit_q  <= 18'h0;
      tick_q <= 1'b0;
    end else if (hold_bit) begin
      bit_q  <= 18'h0;
      tick_q <= tick_d;
    end else begin
      bit_q  <= bit_q + 18'h1;
      tick_q <= 1'b0;
    end
  end
  // ==========================================================
  // Serial engine hold, kept one cycle past the end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idle_q <= 1'b0;
    end else begin
      idle_q <= meas_nxt || measure;
    end
  end
  // ==========================================================
  // Outputs
  assign auto_baud_enable       = en_q;
  assign receive_interrupt_flag = flag_q;
  assign divisor_low_byte       = div_q[7:0];
  assign divisor_high_byte      = div_q[15:8];
  assign serial_idle            = idle_q;
  assign bit_tick               = tick_q;
endmodule

/* sabd_sva.sv */
`timescale 1ns/1ns
module sabd_sva (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // Watched signals
  input wire logic       rx_line,
  input wire logic       receive_data_read,
  input wire logic       div_write,
  input wire logic       auto_baud_enable_set,
  input wire logic       auto_baud_enable,
  input wire logic       receive_interrupt_flag,
  input wire logic       serial_idle,
  input wire logic       bit_tick,
  input wire logic [7:0] divisor_low_byte,
  input wire logic [7:0] divisor_high_byte
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_start_on_set: assert property (
    auto_baud_enable_set && !auto_baud_enable |=> auto_baud_enable)
    else $error("measurement did not start");
  a_idle_hold: assert property (
    auto_baud_enable |-> serial_idle) else $error("not idle");
  a_idle_release: assert property (
    !auto_baud_enable && !$past(auto_baud_enable) |-> !serial_idle)
    else $error("serial engine held after end");
  a_no_tick_measure: assert property (
    auto_baud_enable |-> !bit_tick) else $error("tick while measuring");
  a_flag_on_end: assert property (
    $fell(auto_baud_enable) |-> receive_interrupt_flag)
    else $error("flag not set at end");
  a_flag_cause: assert property (
    $rose(receive_interrupt_flag) |-> $fell(auto_baud_enable))
    else $error("flag without end");
  a_end_on_rise: assert property (
    $fell(auto_baud_enable) |-> $past(rx_line) && !$past(rx_line, 2))
    else $error("end not after rising edge");
  a_read_clears: assert property (
    receive_data_read && !auto_baud_enable |=> !receive_interrupt_flag)
    else $error("read left flag set");
  a_divisor_kept: assert property (
    !auto_baud_enable && !div_write |=>
    $stable({divisor_high_byte, divisor_low_byte}))
    else $error("divisor changed");
endmodule

/* serial_auto_baud_detect_tb.sv */
`timescale 1ns/1ns
module serial_auto_baud_detect_tb
  import sabd_pkg::*;
;
  localparam int unsigned BITC = 512;
  logic        mclk, rstn, set, wk, wd, hs, sm, rd, dw, ss, sb;
  logic [15:0] wdat;
  logic        busy, en, flg, idl, tk;
  logic [7:0]  lo, hi;
  int          errors, tests_run, cyc, n;
  sabd_if link ();
  sabd_remote #(.BIT_CYCLES(BITC)) sabd_remote_i (.mclk(mclk), .rstn(rstn),
    .send_sync(ss), .send_break(sb), .busy(busy), .link(link));
  sabd_device sabd_device_i (.mclk(mclk), .rstn(rstn),
    .auto_baud_enable_set(set), .wake_on_break_enable(wk),
    .wide_divisor_select(wd), .high_speed_select(hs), .sync_mode(sm),
    .receive_data_read(rd), .div_write(dw), .div_wdata(wdat),
    .auto_baud_enable(en), .receive_interrupt_flag(flg),
    .divisor_low_byte(lo), .divisor_high_byte(hi), .serial_idle(idl),
    .bit_tick(tk), .link(link));
  sabd_sva sabd_sva_i (.mclk(mclk), .rstn(rstn), .rx_line(link.rx_line),
    .receive_data_read(rd), .div_write(dw), .auto_baud_enable_set(set),
    .auto_baud_enable(en), .receive_interrupt_flag(flg),
    .serial_idle(idl), .bit_tick(tk), .divisor_low_byte(lo),
    .divisor_high_byte(hi));
  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input logic w, h, brk, input int e);
    @(negedge mclk) {wk, wd, hs, set} = {brk, w, h, 1'b1};
    @(negedge mclk) set = 1'b0;
    check({14'h0, en, idl}, 16'h0003);
    {dw, wdat} = {1'b1, 16'hffff};
    @(negedge mclk) dw = 1'b0;
    if (brk) begin
      sb = 1'b1;
      @(negedge mclk) sb = 1'b0;
      while (busy === 1'b1) @(negedge mclk);
    end
    ss = 1'b1;
    @(negedge mclk) ss = 1'b0;
    n = 0;
    while (flg !== 1'b1 && n < 20000) @(negedge mclk) n++;
    check({14'h0, flg, en}, 16'h0002);
    check({15'h0, {hi, lo} - e + 1 <= 2}, 16'h1);
    if (e < 256) check({8'h0, hi}, 16'h0000);
    rd = 1'b1;
    @(negedge mclk) rd = 1'b0;
    check({14'h0, flg, idl}, 16'h0000);
    while (busy === 1'b1) @(negedge mclk);
  endtask
  task automatic period(input logic s, w, h, input logic [15:0] e);
    @(negedge mclk) {sm, wd, hs} = {s, w, h};
    n = 0;
    while (tk !== 1'b1 && n < 3000) @(negedge mclk) n++;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (tk !== 1'b1 && n < 3000);
    check(n[15:0], e);
  endtask
  // ==========================================================
  // Clock, timeout and tests
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    {rstn, set, wk, wd, hs, sm, rd, dw, ss, sb, wdat} = '0;
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    for (int m = 0; m < 4; m++)
      run(m[1], m[0], 1'b0, BITC / ((m == 0) ? DIV_BOTH_LOW :
        (m == 3) ? DIV_BOTH_HIGH : DIV_ONE_HIGH) + 1);
    run(1'b1, 1'b1, 1'b1, BITC / DIV_BOTH_HIGH + 1);
    @(negedge mclk) {wk, dw, wdat} = {1'b0, 1'b1, 16'h0109};
    @(negedge mclk) dw = 1'b0;
    period(1'b0, 1'b1, 1'b1, 16'h0428);
    period(1'b1, 1'b1, 1'b0, 16'h0428);
    period(1'b0, 1'b1, 1'b0, 16'h0028);
    period(1'b1, 1'b0, 1'b1, 16'h0028);
    give_verdict();
  end
endmodule
